// *** rtl/trap_decoder_pkg.sv ***
package trap_decoder_pkg;
    // Primary opcodes
    localparam logic [5:0] PO_TDI       = 6'h02;
    localparam logic [5:0] PO_TWI       = 6'h03;
    localparam logic [5:0] PO_SYSCALL   = 6'h11;
    localparam logic [5:0] PO_ROTD      = 6'h1e;
    localparam logic [5:0] PO_EXT31     = 6'h1f;
    localparam logic [5:0] PO_LDFORM    = 6'h3a;
    localparam logic [5:0] PO_FPS       = 6'h3b;
    localparam logic [5:0] PO_STDFORM   = 6'h3e;
    localparam logic [5:0] PO_FPD       = 6'h3f;
    // Extended opcodes, primary 31, ten-bit field
    localparam logic [9:0] XO_MFTB      = 10'h173;
    localparam logic [9:0] XO_STFIWX    = 10'h3d7;
    localparam logic [9:0] XO_TLBIA     = 10'h172;
    localparam logic [9:0] XO_TLBIEX    = 10'h152;
    localparam logic [9:0] XO_TLBSYNC   = 10'h236;
    localparam logic [9:0] XO_CNTLZD    = 10'h03a;
    localparam logic [9:0] XO_EXTSW     = 10'h3da;
    localparam logic [9:0] XO_LDARX     = 10'h054;
    localparam logic [9:0] XO_LDUX      = 10'h035;
    localparam logic [9:0] XO_LDX       = 10'h015;
    localparam logic [9:0] XO_LWAUX     = 10'h175;
    localparam logic [9:0] XO_LWAX      = 10'h155;
    localparam logic [9:0] XO_SLBIA     = 10'h1f2;
    localparam logic [9:0] XO_SLBIE     = 10'h1b2;
    localparam logic [9:0] XO_SLBIEX    = 10'h1d2;
    localparam logic [9:0] XO_SLD       = 10'h01b;
    localparam logic [9:0] XO_SRAD      = 10'h31a;
    localparam logic [9:0] XO_SRD       = 10'h21b;
    localparam logic [9:0] XO_STDCX     = 10'h0d6;
    localparam logic [9:0] XO_STDUX     = 10'h0b5;
    localparam logic [9:0] XO_STDX      = 10'h095;
    localparam logic [9:0] XO_TD        = 10'h044;
    localparam logic [9:0] XO_MFSPR     = 10'h153;
    localparam logic [9:0] XO_MTSPR     = 10'h1d3;
    localparam logic [9:0] XO_MTSRIN    = 10'h0f2;
    // Nine-bit fields carrying the overflow-enable bit above them, except SRADI, whose field sits one bit higher
    localparam logic [8:0] XO9_DIVD     = 9'h1e9;
    localparam logic [8:0] XO9_DIVDU    = 9'h1c9;
    localparam logic [8:0] XO9_MULLD    = 9'h0e9;
    localparam logic [8:0] XO9_MULHD    = 9'h049;
    localparam logic [8:0] XO9_MULHDU   = 9'h009;
    localparam logic [8:0] XO9_SRADI    = 9'h19d;
    // Floating point extended opcodes
    localparam logic [4:0] XO5_FRES     = 5'h18;
    localparam logic [4:0] XO5_FRSQRTE  = 5'h1a;
    localparam logic [4:0] XO5_FSEL     = 5'h17;
    localparam logic [4:0] XO5_FSQRT    = 5'h16;
    localparam logic [9:0] XO_FCFID     = 10'h34e;
    localparam logic [9:0] XO_FCTID     = 10'h32e;
    localparam logic [9:0] XO_FCTIDZ    = 10'h32f;
    // Special-register numbers, then divide operand constants and reset values
    localparam logic [9:0] SPR_TIME_BASE_LOWER = 10'd284;
    localparam logic [9:0] SPR_TIME_BASE_UPPER = 10'd285;
    localparam logic [9:0] SPR_DBAT_LO  = 10'd536;
    localparam logic [9:0] SPR_DBAT_HI  = 10'd543;
    localparam logic [9:0] SPR_ADDR_SPACE = 10'd280;
    localparam logic [63:0] DIV_MOST_NEG = 64'h8000_0000_0000_0000;
    localparam logic [63:0] ALL_ONES64   = 64'hffff_ffff_ffff_ffff;
    localparam logic [6:0] CLZ_RESET    = 7'h00;
    localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
endpackage

// *** rtl/unimplemented_opcode_trap_decoder.sv ***
`timescale 1ns/10ps
module unimplemented_opcode_trap_decoder
    import trap_decoder_pkg::*;
(
    input  wire logic        mclk_i,               // Core clock
    input  wire logic        reset_i,              // Synchronous reset, active high
    input  wire logic        insn_valid_i,         // Instruction present this cycle
    input  wire logic [31:0] insn_i,               // Instruction word, bit 31 is the first bit
    input  wire logic [31:0] insn_addr_i,          // Address of the instruction
    input  wire logic        supervisor_i,         // Core runs in supervisor mode
    input  wire logic [63:0] op_a_i,               // Source operand A (dividend / count source)
    input  wire logic [63:0] op_b_i,               // Source operand B (divisor)
    input  wire logic        xer_so_i,             // Current summary-overflow flag
    output logic             done_o,               // Decode result valid
    output logic             trap_illegal_o,       // Illegal-instruction exception
    output logic             trap_priv_o,          // Privileged-instruction exception
    output logic             syscall_o,            // Decoded as system call
    output logic             wb_enable_o,          // Architected write-back allowed
    output logic [31:0]      trap_addr_o,          // Saved return address
    output logic [6:0]       clz_count_o,          // Doubleword leading-zero count
    output logic [63:0]      quotient_o,           // Doubleword quotient
    output logic             result_undef_o,       // Target contents undefined
    output logic             cond_zero_update_o,   // Write condition_field_zero
    output logic [3:0]       condition_field_zero_o, // LT GT EQ SO
    output logic             xer_update_o,         // Write overflow flags
    output logic             overflow_flag_o,      // New overflow_flag
    output logic             summary_overflow_o    // New sticky summary overflow
);
    logic [5:0] prim;
    logic [9:0] xo10;
    logic [8:0] xo9;
    logic [4:0] xo5;
    logic [9:0] spr_num;
    logic       record_bit;
    logic       oe_bit;
    logic       unsup32;
    logic       only64;
    logic       spr_bad;
    logic       spr_sup;
    logic       sup_only;
    logic       is_spr_op;
    logic       is_clz;
    logic       is_divs;
    logic       is_divu;
    logic       illegal_next;
    logic       priv_next;
    logic [6:0] clz_next;
    logic [63:0] quot_next;
    logic       undef_next;
    logic [63:0] result_val;

    assign prim       = insn_i[31:26];
    assign xo10       = insn_i[10:1];
    assign xo9        = insn_i[9:1];
    assign xo5        = insn_i[5:1];
    assign record_bit = insn_i[0];
    assign oe_bit     = insn_i[10];
    // Field holds the low half first, so the halves swap back here
    assign spr_num    = {insn_i[15:11], insn_i[20:16]};

    always_comb begin
        unsup32 = 1'b0;
        if (prim == PO_EXT31 && (xo10 == XO_MFTB || xo10 == XO_STFIWX || xo10 == XO_TLBIA
                                 || xo10 == XO_TLBIEX || xo10 == XO_TLBSYNC)) begin
            unsup32 = 1'b1;
        end
        if ((prim == PO_FPS && (xo5 == XO5_FRES || xo5 == XO5_FSQRT))
            || (prim == PO_FPD && (xo5 == XO5_FRSQRTE || xo5 == XO5_FSEL || xo5 == XO5_FSQRT))) begin
            unsup32 = 1'b1;
        end
    end

    always_comb begin
        only64 = 1'b0;
        if (prim == PO_TDI || prim == PO_ROTD || prim == PO_LDFORM || prim == PO_STDFORM) begin
            only64 = 1'b1;
        end
        if (prim == PO_EXT31) begin
            unique case (xo10)
                XO_CNTLZD, XO_EXTSW, XO_LDARX, XO_LDUX, XO_LDX, XO_LWAUX, XO_LWAX,
                XO_SLBIA, XO_SLBIE, XO_SLBIEX, XO_SLD, XO_SRAD, XO_SRD, XO_STDCX,
                XO_STDUX, XO_STDX, XO_TD: begin
                    only64 = 1'b1;
                end
                default: begin
                end
            endcase
            if (xo9 == XO9_DIVD || xo9 == XO9_DIVDU || xo9 == XO9_MULLD || xo9 == XO9_MULHD
                || xo9 == XO9_MULHDU || insn_i[10:2] == XO9_SRADI) begin
                only64 = 1'b1;
            end
        end
        if (prim == PO_FPD && (xo10 == XO_FCFID || xo10 == XO_FCTID || xo10 == XO_FCTIDZ)) begin
            only64 = 1'b1;
        end
    end

    always_comb begin
        is_spr_op = (prim == PO_EXT31) && (xo10 == XO_MFSPR || xo10 == XO_MTSPR);
        spr_bad   = 1'b0;
        spr_sup   = 1'b0;
        if (is_spr_op) begin
            if (spr_num == SPR_TIME_BASE_LOWER || spr_num == SPR_TIME_BASE_UPPER) begin
                spr_bad = 1'b1;
            end
            if (spr_num >= SPR_DBAT_LO && spr_num <= SPR_DBAT_HI) begin
                spr_bad = 1'b1;
                spr_sup = 1'b1;
            end
            if (spr_num == SPR_ADDR_SPACE) begin
                spr_bad = 1'b1;
                spr_sup = 1'b1;
            end
        end
        sup_only = spr_sup || prim == PO_TWI || (prim == PO_EXT31 && xo10 == XO_MTSRIN);
    end

    // Illegal outranks privileged so the handler sees the unimplemented form first
    assign illegal_next = insn_valid_i && (unsup32 || only64 || spr_bad);
    assign priv_next    = insn_valid_i && !illegal_next && sup_only && !supervisor_i;

    assign is_clz  = prim == PO_EXT31 && xo10 == XO_CNTLZD;
    assign is_divs = prim == PO_EXT31 && xo9 == XO9_DIVD;
    assign is_divu = prim == PO_EXT31 && xo9 == XO9_DIVDU;

    always_comb begin
        clz_next = 7'd64;
        for (int i = 0; i < 64; i++) begin
            if (op_a_i[i]) begin
                clz_next = 7'(63 - i);
            end
        end
    end

    always_comb begin
        quot_next  = 64'h0;
        undef_next = 1'b0;
        if (is_divs) begin
            undef_next = (op_b_i == 64'h0) || (op_a_i == DIV_MOST_NEG && op_b_i == ALL_ONES64);
            if (!undef_next) begin
                quot_next = 64'($signed(op_a_i) / $signed(op_b_i));
            end
        end else if (is_divu) begin
            undef_next = op_b_i == 64'h0;
            if (!undef_next) begin
                quot_next = op_a_i / op_b_i;
            end
        end
    end

    assign result_val = is_clz ? {57'h0, clz_next} : quot_next;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            done_o         <= 1'b0;
            trap_illegal_o <= 1'b0;
            trap_priv_o    <= 1'b0;
            syscall_o      <= 1'b0;
            wb_enable_o    <= 1'b0;
            trap_addr_o    <= ADDR_RESET;
        end else begin
            done_o         <= insn_valid_i;
            trap_illegal_o <= illegal_next;
            trap_priv_o    <= priv_next;
            // Legacy supervisor call shares the primary code, so it decodes as the system call
            syscall_o      <= insn_valid_i && prim == PO_SYSCALL;
            wb_enable_o    <= insn_valid_i && !illegal_next && !priv_next;
            trap_addr_o    <= (illegal_next || priv_next) ? insn_addr_i : trap_addr_o;
        end
    end

    // Result path serves the trap handler's emulation, so it runs even when the decode traps
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            clz_count_o            <= CLZ_RESET;
            quotient_o             <= 64'h0;
            result_undef_o         <= 1'b0;
            cond_zero_update_o     <= 1'b0;
            condition_field_zero_o <= 4'h0;
            xer_update_o           <= 1'b0;
            overflow_flag_o        <= 1'b0;
            summary_overflow_o     <= 1'b0;
        end else begin
            clz_count_o    <= clz_next;
            quotient_o     <= quot_next;
            result_undef_o <= insn_valid_i && undef_next;
            cond_zero_update_o <= insn_valid_i && record_bit && (is_clz || is_divs || is_divu);
            // Undefined result leaves the compare bits meaningless; they read zero
            condition_field_zero_o <= {!undef_next && $signed(result_val) < 0,
                                       !undef_next && $signed(result_val) > 0,
                                       !undef_next && result_val == 64'h0,
                                       xer_so_i || (oe_bit && undef_next)};
            xer_update_o    <= insn_valid_i && oe_bit && (is_divs || is_divu);
            overflow_flag_o <= undef_next;
            summary_overflow_o <= xer_so_i || undef_next;
        end
    end

    property p_illegal_time_base;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && is_spr_op && spr_num == SPR_TIME_BASE_UPPER |=> trap_illegal_o;
    endproperty
    a_illegal_time_base: assert property (p_illegal_time_base) else $error("time base upper not trapped");

    property p_illegal_dbat;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && is_spr_op && spr_num >= 10'd536 && spr_num <= 10'd543 |=> trap_illegal_o;
    endproperty
    a_illegal_dbat: assert property (p_illegal_dbat) else $error("data translation spr not trapped");

    property p_addr_space;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && is_spr_op && spr_num == 10'd280 |=> trap_illegal_o && !trap_priv_o;
    endproperty
    a_addr_space: assert property (p_addr_space) else $error("address space spr not trapped");

    property p_div64;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && (is_divs || is_divu || is_clz) |=> trap_illegal_o && !wb_enable_o;
    endproperty
    a_div64: assert property (p_div64) else $error("64-bit operation executed");

    property p_priv;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && prim == PO_TWI && !supervisor_i |=> trap_priv_o;
    endproperty
    a_priv: assert property (p_priv) else $error("user trap immediate not refused");

    property p_precise;
        @(posedge mclk_i) disable iff (reset_i)
        (trap_illegal_o || trap_priv_o) |-> !wb_enable_o && trap_addr_o == $past(insn_addr_i);
    endproperty
    a_precise: assert property (p_precise) else $error("trap not precise");

    property p_clz_range;
        @(posedge mclk_i) disable iff (reset_i)
        done_o |-> clz_count_o <= 7'd64 && (clz_count_o == 7'd64) == ($past(op_a_i) == 64'h0);
    endproperty
    a_clz_range: assert property (p_clz_range) else $error("leading zero count wrong");

    property p_sdiv_trunc;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && is_divs && op_a_i == 64'd7 && op_b_i == ALL_ONES64 - 64'd1
        |=> quotient_o == ALL_ONES64 - 64'd2;
    endproperty
    a_sdiv_trunc: assert property (p_sdiv_trunc) else $error("signed quotient not truncated");

    property p_undef;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && (is_divs || is_divu) && op_b_i == 64'h0 |=> result_undef_o ##0 !condition_field_zero_o[1];
    endproperty
    a_undef: assert property (p_undef) else $error("divide by zero not flagged");

    property p_xer;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && is_divu && oe_bit |=> xer_update_o && (summary_overflow_o || !overflow_flag_o);
    endproperty
    a_xer: assert property (p_xer) else $error("overflow flags not updated");

    property p_cr0;
        @(posedge mclk_i) disable iff (reset_i)
        cond_zero_update_o |-> $past(record_bit) && $past(insn_valid_i);
    endproperty
    a_cr0: assert property (p_cr0) else $error("condition field written without record bit");

    property p_unsup_sync;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && prim == PO_EXT31 && xo10 == XO_TLBSYNC |=> trap_illegal_o && !wb_enable_o;
    endproperty
    a_unsup_sync: assert property (p_unsup_sync) else $error("unsupported sync not trapped");

    property p_shift_imm64;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && prim == PO_EXT31 && insn_i[10:2] == XO9_SRADI |=> trap_illegal_o;
    endproperty
    a_shift_imm64: assert property (p_shift_imm64) else $error("doubleword shift immediate not trapped");

    property p_seg_write_user;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && prim == PO_EXT31 && xo10 == XO_MTSRIN && !supervisor_i |=> trap_priv_o && !wb_enable_o;
    endproperty
    a_seg_write_user: assert property (p_seg_write_user) else $error("user segment write not refused");

    property p_syscall;
        @(posedge mclk_i) disable iff (reset_i)
        insn_valid_i && prim == PO_SYSCALL |=> syscall_o && !trap_illegal_o;
    endproperty
    a_syscall: assert property (p_syscall) else $error("system call not decoded");

    c_illegal: cover property (@(posedge mclk_i) disable iff (reset_i) trap_illegal_o);
    c_priv:    cover property (@(posedge mclk_i) disable iff (reset_i) trap_priv_o);
    c_sys:     cover property (@(posedge mclk_i) disable iff (reset_i) syscall_o);
    c_undef:   cover property (@(posedge mclk_i) disable iff (reset_i) result_undef_o && cond_zero_update_o);
endmodule // unimplemented_opcode_trap_decoder

// *** sim/fetch_model.sv ***
`timescale 1ns/10ps
module fetch_model (
    input  wire logic        mclk_i,   // Core clock
    output logic             valid_o,  // Instruction present
    output logic [31:0]      insn_o,   // Instruction word
    output logic [31:0]      addr_o    // Instruction address
);
    // An idle fetch bus shows the inverse of the last word, so a stale copy never passes
    task automatic go_idle();
        valid_o = 1'b0;
        insn_o  = ~insn_o;
        addr_o  = ~addr_o;
    endtask

    // One word, or two words back to back when two is set
    task automatic send2(input logic [31:0] a, input logic [31:0] b, input logic [31:0] pc, input bit two);
        @(posedge mclk_i);
        #1;
        valid_o = 1'b1;
        insn_o  = a;
        addr_o  = pc;
        @(posedge mclk_i);
        #1;
        if (two) begin
            insn_o = b;
            addr_o = pc + 32'h4;
            @(posedge mclk_i);
            #1;
        end
        go_idle();
    endtask

    initial begin
        valid_o = 1'b0;
        insn_o  = 32'h0;
        addr_o  = 32'h0;
    end
endmodule // fetch_model

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
    import trap_decoder_pkg::*;
;
    logic        mclk_i, reset_i, insn_valid_i, supervisor_i, xer_so_i;
    logic [31:0] insn_i, insn_addr_i, trap_addr_o, pc, last_trap;
    logic [63:0] op_a_i, op_b_i, quotient_o;
    logic        done_o, trap_illegal_o, trap_priv_o, syscall_o, wb_enable_o;
    logic        result_undef_o, cond_zero_update_o, xer_update_o, overflow_flag_o, summary_overflow_o;
    logic [6:0]  clz_count_o;
    logic [3:0]  condition_field_zero_o;
    int          err_total, tests_run;

    fetch_model i_fetch (.mclk_i(mclk_i), .valid_o(insn_valid_i), .insn_o(insn_i), .addr_o(insn_addr_i));
    unimplemented_opcode_trap_decoder i_dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
        .insn_addr_i(insn_addr_i), .supervisor_i(supervisor_i), .op_a_i(op_a_i), .op_b_i(op_b_i),
        .xer_so_i(xer_so_i), .done_o(done_o), .trap_illegal_o(trap_illegal_o), .trap_priv_o(trap_priv_o),
        .syscall_o(syscall_o), .wb_enable_o(wb_enable_o), .trap_addr_o(trap_addr_o),
        .clz_count_o(clz_count_o), .quotient_o(quotient_o), .result_undef_o(result_undef_o),
        .cond_zero_update_o(cond_zero_update_o), .condition_field_zero_o(condition_field_zero_o),
        .xer_update_o(xer_update_o), .overflow_flag_o(overflow_flag_o), .summary_overflow_o(summary_overflow_o));

    function automatic logic [31:0] xf(input logic [5:0] po, input logic [9:0] xo);
        return {po, 15'h0, xo, 1'b0};
    endfunction
    function automatic logic [31:0] sprf(input logic [9:0] xo, input logic [9:0] spr);
        return {PO_EXT31, 5'h0, spr[4:0], spr[9:5], xo, 1'b0};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Issues one word and judges the trap outcome; trap_addr_o must keep the last trapped address
    task automatic run(input logic [31:0] w, input logic sup, input logic ill, input logic priv);
        supervisor_i = sup;
        i_fetch.send2(w, 32'h0, pc, 1'b0);
        if (ill || priv) begin
            last_trap = pc;
        end
        check(done_o, 1'b1);
        check(trap_illegal_o, ill);
        check(trap_priv_o, priv);
        check(wb_enable_o, !(ill || priv));
        check(trap_addr_o, last_trap);
        check(syscall_o, w[31:26] == PO_SYSCALL);
        pc = pc + 32'h4;
    endtask

    task automatic t_reset();
        @(posedge mclk_i);
        #1;
        check({done_o, trap_illegal_o, wb_enable_o}, 3'h0);
        check(trap_addr_o, ADDR_RESET);
    endtask

    task automatic t_unsupported32();
        logic [31:0] w[10] = '{{PO_FPS, 20'h0, XO5_FRES, 1'b0}, {PO_FPD, 20'h0, XO5_FRSQRTE, 1'b0},
            {PO_FPD, 20'h0, XO5_FSEL, 1'b0}, {PO_FPD, 20'h0, XO5_FSQRT, 1'b0}, {PO_FPS, 20'h0, XO5_FSQRT, 1'b0},
            sprf(XO_MFTB, 10'd268), xf(PO_EXT31, XO_STFIWX), xf(PO_EXT31, XO_TLBIA),
            xf(PO_EXT31, XO_TLBIEX), xf(PO_EXT31, XO_TLBSYNC)};
        foreach (w[i]) begin
            run(w[i], 1'b1, 1'b1, 1'b0);
        end
    endtask

    // User mode on purpose: no word here is privileged, so only the illegal trap may fire
    task automatic t_only64();
        logic [31:0] w[24] = '{xf(PO_EXT31, XO_CNTLZD), xf(PO_EXT31, XO_EXTSW), xf(PO_EXT31, XO_LDARX),
            xf(PO_EXT31, XO_LDUX), xf(PO_EXT31, XO_LDX), xf(PO_EXT31, XO_LWAUX), xf(PO_EXT31, XO_LWAX),
            xf(PO_EXT31, XO_SLBIA), xf(PO_EXT31, XO_SLBIE), xf(PO_EXT31, XO_SLBIEX), xf(PO_EXT31, XO_SLD),
            xf(PO_EXT31, XO_SRAD), xf(PO_EXT31, XO_SRD), {PO_EXT31, 15'h0, XO_STDCX, 1'b1},
            xf(PO_EXT31, XO_STDUX), xf(PO_EXT31, XO_STDX), xf(PO_EXT31, XO_TD), xf(PO_FPD, XO_FCFID),
            xf(PO_FPD, XO_FCTID), xf(PO_FPD, XO_FCTIDZ), {PO_TDI, 26'h0}, {PO_ROTD, 26'h0},
            {PO_LDFORM, 26'h1}, {PO_STDFORM, 26'h1}};
        logic [8:0] x9[5] = '{XO9_DIVD, XO9_DIVDU, XO9_MULLD, XO9_MULHD, XO9_MULHDU};
        foreach (w[i]) begin
            run(w[i], 1'b0, 1'b1, 1'b0);
        end
        foreach (x9[i]) begin
            run({PO_EXT31, 16'h0, x9[i], 1'b0}, 1'b0, 1'b1, 1'b0);
            check({cond_zero_update_o, xer_update_o}, 2'b00);
        end
        run({PO_EXT31, 15'h0, XO9_SRADI, 2'b10}, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_spr();
        logic [9:0] s[15] = '{10'd284, 10'd285, 10'd536, 10'd537, 10'd538, 10'd539, 10'd540, 10'd541,
            10'd542, 10'd543, 10'd280, 10'd283, 10'd286, 10'd535, 10'd544};
        foreach (s[i]) begin
            run(sprf(XO_MFSPR, s[i]), 1'b1, i < 11, 1'b0);
        end
        run(sprf(XO_MTSPR, SPR_ADDR_SPACE), 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_priv();
        run({PO_TWI, 26'h0}, 1'b0, 1'b0, 1'b1);
        run(xf(PO_EXT31, XO_MTSRIN), 1'b0, 1'b0, 1'b1);
        run({PO_TWI, 26'h0}, 1'b1, 1'b0, 1'b0);
        run(xf(PO_EXT31, XO_MTSRIN), 1'b1, 1'b0, 1'b0);
        run({PO_SYSCALL, 24'h0, 2'b10}, 1'b0, 1'b0, 1'b0);
        check(syscall_o, 1'b1);
    endtask

    task automatic t_clz();
        logic [63:0] a[4] = '{64'h0, 64'h1, DIV_MOST_NEG, 64'h0000_0001_0000_0000};
        logic [6:0]  n[4] = '{7'd64, 7'd63, 7'd0, 7'd31};
        foreach (a[i]) begin
            op_a_i   = a[i];
            xer_so_i = i[0];
            run({PO_EXT31, 15'h0, XO_CNTLZD, 1'b1}, 1'b1, 1'b1, 1'b0);
            check(clz_count_o, n[i]);
            check(cond_zero_update_o, 1'b1);
            check(condition_field_zero_o, {1'b0, n[i] != 0, n[i] == 0, i[0]});
        end
    endtask

    task automatic t_div();
        logic [63:0] a[7] = '{64'hffff_ffff_ffff_fff9, 64'h7, DIV_MOST_NEG, 64'h5, ALL_ONES64, 64'h9, DIV_MOST_NEG};
        logic [63:0] b[7] = '{64'h2, 64'hffff_ffff_ffff_fffe, ALL_ONES64, 64'h0, 64'h3, 64'h0, 64'h2};
        bit          u[7] = '{0, 0, 0, 0, 1, 1, 0};
        bit          oe[7] = '{1, 0, 1, 0, 1, 1, 1};
        logic [63:0] q;
        logic        bad;
        foreach (a[i]) begin
            op_a_i   = a[i];
            op_b_i   = b[i];
            xer_so_i = i[1];
            bad = (b[i] == 64'h0) || (!u[i] && a[i] == DIV_MOST_NEG && b[i] == ALL_ONES64);
            // Kept apart from the unsigned case: a shared conditional would force unsigned division
            if (bad) begin
                q = 64'h0;
            end else if (u[i]) begin
                q = a[i] / b[i];
            end else begin
                q = $signed(a[i]) / $signed(b[i]);
            end
            run({PO_EXT31, 15'h0, oe[i], u[i] ? XO9_DIVDU : XO9_DIVD, 1'b1}, 1'b1, 1'b1, 1'b0);
            check(quotient_o, q);
            check(result_undef_o, bad);
            check(cond_zero_update_o, 1'b1);
            check(condition_field_zero_o, {!bad && $signed(q) < 0, !bad && $signed(q) > 0,
                !bad && q == 0, i[1] | (oe[i] & bad)});
            check(xer_update_o, oe[i]);
            if (oe[i]) begin
                check({overflow_flag_o, summary_overflow_o}, {bad, i[1] | bad});
            end
        end
    endtask

    task automatic t_b2b();
        fork
            i_fetch.send2({PO_FPS, 20'h0, XO5_FRES, 1'b0}, {6'h0e, 26'h0}, pc, 1'b1);
            begin
                repeat (2) @(posedge mclk_i);
                #2;
                check({done_o, trap_illegal_o, trap_addr_o}, {2'b11, pc});
                @(posedge mclk_i);
                #2;
                check({done_o, trap_illegal_o, wb_enable_o, trap_addr_o}, {3'b101, pc});
                @(posedge mclk_i);
                #2;
                check(done_o, 1'b0);
            end
        join
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    // About 155 cycles of traffic are expected; the limit leaves wide margin
    initial begin
        #20000;
        err_total++;
        finish_test();
    end

    initial begin
        err_total    = 0;
        tests_run    = 0;
        reset_i      = 1'b1;
        supervisor_i = 1'b0;
        xer_so_i     = 1'b0;
        op_a_i       = 64'h0;
        op_b_i       = 64'h0;
        pc           = 32'h0000_1000;
        last_trap    = ADDR_RESET;
        repeat (6) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_unsupported32();
        t_only64();
        t_spr();
        t_priv();
        t_clz();
        t_div();
        t_b2b();
        finish_test();
    end
endmodule // tb_top
